//--- burst4_pkg.sv
// Shared constants for the burst-of-four double-rate memory port
package burst4_pkg;
  localparam int LANE_BITS = 9;            // Bits per byte lane, parity included
  localparam int LANES_WIDE = 4;           // Lane count of the 36-bit variant
  localparam int BURST_LEN = 4;            // Beats per read or write burst
  localparam int BEAT_W = 2;               // Width of the beat index
  localparam int BURST_ADDR_W = 19;        // Burst address width of the 36-bit variant
  localparam logic [2:0] WR_CNT_START = 3'h5;  // Load value: one gap cycle, then four beats
  localparam logic [2:0] WR_CNT_FIRST = 3'h4;  // Counter value on the first write beat
  localparam logic [1:0] RD_LEFT_START = 2'h3; // Read beats issued after the first
  localparam logic PHASE_RESET = 1'b0;     // Reset phase: first cycle is a main-clock edge
endpackage : burst4_pkg

//--- lane_masked_mem.sv
// Storage array with a registered read port and per-lane write enables
`timescale 1ns/100ps
module lane_masked_mem #(
  parameter int LANES = burst4_pkg::LANES_WIDE, // Byte lanes per word
  parameter int AW = burst4_pkg::BURST_ADDR_W + burst4_pkg::BEAT_W // Word address width
) (
  input wire logic clk, // Core clock
  input wire logic rd_en, // Read strobe
  input wire logic [AW-1:0] rd_addr, // Read word address
  output logic [LANES*burst4_pkg::LANE_BITS-1:0] rd_data, // Registered read word
  input wire logic [LANES-1:0] wr_lane_en, // One write enable per lane
  input wire logic [AW-1:0] wr_addr, // Write word address
  input wire logic [LANES*burst4_pkg::LANE_BITS-1:0] wr_data // Write word
);
  import burst4_pkg::*;

  // Storage split per lane so each array has a single writer; a masked lane keeps its bits
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_BITS-1:0] mem [0:(1<<AW)-1];
    // Read holds its last word when not strobed, so a stopped port keeps its data
    always_ff @(posedge clk) begin
      if (rd_en) begin
        rd_data[l*LANE_BITS +: LANE_BITS] <= mem[rd_addr];
      end
      if (wr_lane_en[l]) begin
        mem[wr_addr] <= wr_data[l*LANE_BITS +: LANE_BITS];
      end
    end
  end
endmodule : lane_masked_mem

//--- burst4_ddr_sram_sync_port.sv
// Command decode, burst sequencing and byte-lane writes of the double-rate memory port
//
// How it works
// - Clock stop waits for accepted bursts to finish; stopped outputs hold.
// - A request needs its select high on the previous main edge; repeats ignored.
// - A write right after a read ignores the read select.
// - Lane enables arrive with every data beat, on both clock edges.
// - Lane enables act only during beats of an accepted write.
// - All enables low write every lane; all high write nothing; else per lane.
// - Wide variant: upper two enables low write only the upper two lanes.
// - Narrow variant has two enables, one per nine-bit lane, same encoding.
// - First write beat on next main edge, then alternating edges, four beats.
// - Read data starts after the next complement edge, four alternating beats.
// - After a read with no follow-up, outputs go high impedance next main edge.
// - Enable n governs data bits 9n to 9n+8.
//
// One clk cycle is one half-period of the main clock: phase 0 stands for the main
// rising edge, phase 1 for its complement, so every beat has a cycle of its own.
`timescale 1ns/100ps
module burst4_ddr_sram_sync_port #(
  parameter int LANES = burst4_pkg::LANES_WIDE, // 4 for the wide, 2 for the narrow variant
  parameter int ADDR_W = burst4_pkg::BURST_ADDR_W // Burst address width
) (
  input wire logic clk, // Core clock, one cycle per half main period
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic read_sel_n, // Read select, active low
  input wire logic write_sel_n, // Write select, active low
  input wire logic [ADDR_W-1:0] addr, // Common burst address
  input wire logic [LANES*burst4_pkg::LANE_BITS-1:0] wdata, // Write beat data
  input wire logic [LANES-1:0] lane_mask_n, // Per-lane write enables, active low
  input wire logic stop_req, // Request to enter the stopped-clock state
  output logic [LANES*burst4_pkg::LANE_BITS-1:0] rdata, // Read beat data
  output logic rdata_oe, // High while the read outputs are driven
  output logic stopped // High while in the stopped-clock state
);
  import burst4_pkg::*;

  localparam int DW = LANES * LANE_BITS;
  localparam int MW = ADDR_W + BEAT_W;

  typedef struct packed {
    logic phase;
    logic stopped;
    logic prev_rsel_n;
    logic prev_wsel_n;
    logic rd_prev;
    logic [1:0] rd_left;
    logic [ADDR_W-1:0] rd_base;
    logic [BEAT_W-1:0] rd_beat;
    logic issue_q;
    logic out_valid;
    logic [DW-1:0] rdata;
    logic [2:0] wr_cnt;
    logic [ADDR_W-1:0] wr_base;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_pend_base;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic k_edge;
  logic blocked;
  logic rd_go;
  logic wr_go;
  logic rd_issue;
  logic [MW-1:0] rd_addr;
  logic wr_beat;
  logic [BEAT_W-1:0] wr_beat_idx;
  logic [LANES-1:0] lane_we;
  logic [DW-1:0] mem_q;
  logic idle;

  // Request decode on main edges; stop request also blocks new bursts
  always_comb begin
    k_edge = (s_q.phase == PHASE_RESET);
    blocked = s_q.stopped | stop_req;
    rd_go = k_edge & ~blocked & ~read_sel_n & s_q.prev_rsel_n;
    // Read select counts as high for a write directly after a read
    wr_go = k_edge & ~blocked & ~write_sel_n & s_q.prev_wsel_n
            & (read_sel_n | s_q.rd_prev) & ~rd_go;
  end

  // Read issue: beat 0 from the live address, later beats from the stored base
  always_comb begin
    rd_issue = rd_go | (s_q.rd_left != 2'h0);
    rd_addr = rd_go ? {addr, {BEAT_W{1'b0}}} : {s_q.rd_base, s_q.rd_beat};
  end

  // Write beats run while the counter is 4 down to 1
  always_comb begin
    wr_beat = (s_q.wr_cnt != 3'h0) && (s_q.wr_cnt <= WR_CNT_FIRST);
    wr_beat_idx = BEAT_W'(WR_CNT_FIRST - s_q.wr_cnt);
    idle = (s_q.rd_left == 2'h0) & ~s_q.issue_q & ~s_q.out_valid
           & (s_q.wr_cnt == 3'h0) & ~s_q.wr_pend;
  end

  // Lane enables taken in the same beat as the data, gated to write beats
  for (genvar l = 0; l < LANES; l++) begin : g_lane_we
    assign lane_we[l] = wr_beat & ~lane_mask_n[l];
  end

  lane_masked_mem #(
    .LANES(LANES),
    .AW(MW)
  ) u_mem (
    .clk(clk),
    .rd_en(rd_issue),
    .rd_addr(rd_addr),
    .rd_data(mem_q),
    .wr_lane_en(lane_we),
    .wr_addr({s_q.wr_base, wr_beat_idx}),
    .wr_data(wdata)
  );

  // Next state; a stopped port freezes everything but its exit
  always_comb begin
    s_d = s_q;
    if (s_q.stopped) begin
      if (!stop_req) begin
        s_d.stopped = 1'b0;
      end
    end else begin
      s_d.phase = ~s_q.phase;
      if (k_edge) begin
        s_d.prev_rsel_n = read_sel_n;
        s_d.prev_wsel_n = write_sel_n;
        s_d.rd_prev = rd_go;
        // Enter stop only on a main edge with nothing in flight
        if (stop_req && idle) begin
          s_d.stopped = 1'b1;
        end
      end
      // Read sequencing and the two-stage output pipe
      if (rd_go) begin
        s_d.rd_base = addr;
        s_d.rd_beat = BEAT_W'(1);
        s_d.rd_left = RD_LEFT_START;
      end else if (s_q.rd_left != 2'h0) begin
        s_d.rd_left = s_q.rd_left - 2'h1;
        s_d.rd_beat = s_q.rd_beat + BEAT_W'(1);
      end
      s_d.issue_q = rd_issue;
      s_d.out_valid = s_q.issue_q;
      if (s_q.issue_q) begin
        s_d.rdata = mem_q;
      end
      // Write counter; a second write lands while the first still runs
      if (s_q.wr_cnt == 3'h1 && s_q.wr_pend) begin
        s_d.wr_cnt = WR_CNT_FIRST;
        s_d.wr_base = s_q.wr_pend_base;
        s_d.wr_pend = 1'b0;
      end else if (s_q.wr_cnt != 3'h0) begin
        s_d.wr_cnt = s_q.wr_cnt - 3'h1;
      end
      if (wr_go) begin
        if (s_q.wr_cnt == 3'h0) begin
          s_d.wr_cnt = WR_CNT_START;
          s_d.wr_base = addr;
        end else begin
          s_d.wr_pend = 1'b1;
          s_d.wr_pend_base = addr;
        end
      end
    end
  end

  // Single state register; prev selects reset high so no request is lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.phase <= PHASE_RESET;
      s_q.prev_rsel_n <= 1'b1;
      s_q.prev_wsel_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign rdata_oe = s_q.out_valid;
  assign stopped = s_q.stopped;

  // Checks on decode, burst timing and lane gating
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_idle_both_high: assert property (read_sel_n && write_sel_n |-> !rd_go && !wr_go)
    else $error("request taken with both selects high");
  a_read_spacing: assert property (rd_go |=> !rd_go [*3])
    else $error("read accepted on consecutive main edges");
  a_write_spacing: assert property (wr_go |=> !wr_go [*3])
    else $error("write accepted on consecutive main edges");
  a_write_after_read: assert property (k_edge && !blocked && s_q.rd_prev && !write_sel_n
    && s_q.prev_wsel_n |-> wr_go)
    else $error("write after read was refused");
  a_write_beats: assert property (wr_go |-> ##2 wr_beat [*4])
    else $error("write beats not on the four following cycles");
  a_read_beats: assert property (rd_go |-> ##2 rdata_oe [*4])
    else $error("read data not driven for four beats");
  a_read_release: assert property (rd_go ##4 !rd_go |-> ##2 !rdata_oe)
    else $error("read outputs not released after the burst");
  a_lane_gate: assert property (!wr_beat |-> lane_we == '0)
    else $error("lane written outside a write beat");
  a_lane_map: assert property (wr_beat |-> lane_we == ~lane_mask_n)
    else $error("lane enables do not follow the masks");
  a_stop_hold: assert property (stopped && $past(stopped) |-> $stable(rdata) && !wr_beat)
    else $error("stopped port changed state");
  a_stop_drained: assert property ($rose(stopped) |-> $past(idle))
    else $error("stopped with bursts in flight");

  c_read_burst: cover property (rd_go ##4 rd_go);
  c_write_burst: cover property (wr_go ##4 wr_go);
  c_write_after_read: cover property (rd_go ##2 wr_go);
  c_stop: cover property ($rose(stopped));
endmodule : burst4_ddr_sram_sync_port

//--- ctrl_model.sv
// Controller model: replays a per-cycle script onto the command and write ports
`timescale 1ns/100ps
module ctrl_model (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Reset, active low
  output logic read_sel_n, // Read select
  output logic write_sel_n, // Write select
  output logic [3:0] addr, // Burst address
  output logic [35:0] wdata, // Beat data
  output logic [3:0] lane_mask_n, // Lane enables
  input wire logic [35:0] rdata, // Read beat
  input wire logic rdata_oe // Read drive
);
  int c = 0;
  int k;
  bit rs[128], ws[128]; // Select low in that cycle
  logic [3:0] ad[128], mk[128];
  logic [35:0] wd[128], cap[128];
  logic oc[128];
  // Idle levels until the script starts
  initial {read_sel_n, write_sel_n, addr, wdata, lane_mask_n} = '1;
  // Cycle count from release; even counts are main edges
  always @(posedge clk) c <= reset_n ? c + 1 : 0;
  // Drive just after the edge; capture once the read port has settled
  always @(posedge clk) begin
    #1;
    k = c < 128 ? c : 0;
    read_sel_n = !rs[k];
    write_sel_n = !ws[k];
    addr = ad[k];
    wdata = wd[k];
    lane_mask_n = mk[k];
    cap[k] = rdata;
    oc[k] = rdata_oe;
  end
endmodule : ctrl_model

//--- burst4_ddr_sram_sync_port_test.sv
// Self-checking bench for the double-rate burst memory port
`timescale 1ns/100ps
module burst4_ddr_sram_sync_port_test;
  import burst4_pkg::*;
  typedef struct {bit wr; int c; logic [3:0] a; logic [15:0] m; bit [1:0] x;} row_t;
  logic clk, reset_n, stop_req, read_sel_n, write_sel_n, rdata_oe, stopped;
  logic [3:0] addr, lane_mask_n;
  logic [35:0] wdata, rdata;
  logic [17:0] rdata_nr, cap_nr[128];
  logic stopped_nr;
  logic [35:0] ref_mem[64], ex[128];
  bit eo[128];
  int mismatches, n_tests;
  // Ops: write flag, cycle, address, beat masks, hold or read-low extras
  row_t rows[13] = '{
    '{1, 2, 4'h1, 16'h0000, 2'h0}, '{1, 6, 4'h2, 16'h0000, 2'h0},
    '{1, 10, 4'h1, 16'hE3CF, 2'h0}, // Mixed masks per beat
    '{0, 20, 4'h1, 16'h0000, 2'h0},
    '{1, 22, 4'h3, 16'h0000, 2'h2}, // Read select left low
    '{0, 28, 4'h2, 16'h0000, 2'h0}, '{0, 32, 4'h3, 16'h0000, 2'h0},
    '{0, 36, 4'h1, 16'h0000, 2'h1}, // Repeat read dropped
    '{1, 44, 4'h3, 16'h0000, 2'h1}, // Repeat write dropped
    '{0, 56, 4'h3, 16'h0000, 2'h0}, '{0, 60, 4'h1, 16'h0000, 2'h0},
    '{1, 62, 4'h2, 16'h7BD0, 2'h0}, // Write after read, read select raised
    '{0, 80, 4'h2, 16'h0000, 2'h0}};

  ctrl_model P (.clk(clk), .reset_n(reset_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .addr(addr), .wdata(wdata), .lane_mask_n(lane_mask_n),
    .rdata(rdata), .rdata_oe(rdata_oe));
  burst4_ddr_sram_sync_port #(.LANES(4), .ADDR_W(4)) DUT (.clk(clk), .reset_n(reset_n),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr), .wdata(wdata),
    .lane_mask_n(lane_mask_n), .stop_req(stop_req), .rdata(rdata), .rdata_oe(rdata_oe),
    .stopped(stopped));
  burst4_ddr_sram_sync_port #(.LANES(2), .ADDR_W(4)) DUT_NARROW (.clk(clk),
    .reset_n(reset_n), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr),
    .wdata(wdata[17:0]), .lane_mask_n(lane_mask_n[1:0]), .stop_req(stop_req),
    .rdata(rdata_nr), .rdata_oe(), .stopped(stopped_nr));

  // Narrow copy's read port, taken at the same moment as the model's capture
  always @(posedge clk) begin
    #1;
    if (P.c < 128) cap_nr[P.c] = rdata_nr;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk_word(logic [35:0] got, logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(logic got, logic exp);
    chk_word({35'h0, got}, {35'h0, exp});
  endtask : chk_bit

  // Bounded wait on the model's cycle count; a stall ends the run
  task automatic wait_c(int n);
    for (int t = 0; t < 300 && P.c < n; t++) @(posedge clk);
    #1;
    if (P.c < n) begin
      mismatches++;
      summarize();
    end
  endtask : wait_c

  // Script one op and update the reference memory in order
  task automatic put(row_t r);
    if (r.wr) P.ws[r.c] = 1'b1;
    else P.rs[r.c] = 1'b1;
    P.ad[r.c] = r.a;
    P.ad[r.c + 2] = r.a;
    if (r.x[0] && r.wr) P.ws[r.c + 2] = 1'b1;
    if (r.x[0] && !r.wr) P.rs[r.c + 2] = 1'b1;
    if (r.x[1]) P.rs[r.c] = 1'b1;
    for (int b = 0; b < 4; b++) begin
      if (r.wr) begin
        P.wd[r.c + 2 + b] = 36'(36'h123456789 * (r.c + b + 1));
        P.mk[r.c + 2 + b] = r.m[b * 4 +: 4];
        for (int l = 0; l < 4; l++) begin
          if (!r.m[b * 4 + l]) begin
            ref_mem[{r.a, 2'(b)}][l * 9 +: 9] = P.wd[r.c + 2 + b][l * 9 +: 9];
          end
        end
      end else begin
        ex[r.c + 2 + b] = ref_mem[{r.a, 2'(b)}];
        eo[r.c + 2 + b] = 1'b1;
      end
    end
  endtask : put

  // Free-running core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    stop_req = 1'b0;
    // Enables left low and data toggling outside bursts
    for (int i = 0; i < 128; i++) begin
      P.wd[i] = i[0] ? 36'hA5A5A5A5A : 36'h5A5A5A5A5;
      P.mk[i] = 4'h0;
      P.ad[i] = i[3:0];
    end
    foreach (rows[i]) put(rows[i]);
    repeat (10) @(posedge clk);
    #1;
    chk_word(rdata, 36'h0);
    chk_bit(rdata_oe, 1'b0);
    chk_bit(stopped, 1'b0);
    reset_n = 1'b1;
    $display("reset test done");
    // Stop asked for with a read in flight
    wait_c(81);
    stop_req = 1'b1;
    wait_c(95);
    for (int i = 2; i < 90; i++) begin
      chk_bit(P.oc[i], eo[i]);
      if (eo[i]) begin
        chk_word(P.cap[i], ex[i]);
        chk_word({18'h0, cap_nr[i]}, {18'h0, ex[i][17:0]});
      end
    end
    $display("burst rows test done");
    chk_bit(stopped, 1'b1);
    chk_bit(stopped_nr, 1'b1);
    chk_word(rdata, ex[85]);
    chk_bit(rdata_oe, 1'b0);
    stop_req = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_bit(stopped, 1'b0);
    $display("stop test done");
    summarize();
  end
endmodule : burst4_ddr_sram_sync_port_test
